// File: core/optical_tx_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "tx_ctrl_defines.svh"
// How it works
// RQ1: laser off within 10 us of disable
// RQ2: laser back on within 1 ms
// RQ3: initialization done within 300 ms
// RQ4: fault flag raised within 100 us; in run, a fault is not flagged while disable is held
// RQ5: host holds disable 10 us to clear
// RQ6: signal-lost asserts between 2.3 and 100 us
// RQ7: signal-lost clears within 100 us
// RQ8: host clocks id link at 100 kHz max
// RQ9: fault flag latched until reset or power
module optical_tx_ctrl #(
  parameter int INIT_CYCLES = `T_INIT_NS / `CLK_NS,
  parameter int ON_CYCLES = `T_ON_NS / `CLK_NS
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // host pins
  input wire logic tx_disable,
  output logic tx_fault,
  output logic receive_signal_lost,
  // internal monitors and laser control
  input wire logic laser_fault,
  input wire logic rx_power_low,
  output logic laser_enable
);
  // ***********************************************************
  // constants
  // ***********************************************************
  localparam int RESET_CYC = (`T_RESET_NS + `CLK_NS - 1) / `CLK_NS;
  localparam int LOSS_CYC = (`T_LOSS_MIN_NS + `CLK_NS - 1) / `CLK_NS;
  localparam int CW = 32;

  // refused at elaboration: init may never outlast its own limit
  if (INIT_CYCLES < 1 || ON_CYCLES < 1 || ON_CYCLES > INIT_CYCLES)
  begin : g_bad_timing
    $error("bad timing parameters");
  end

  // ***********************************************************
  // pin synchronisers
  // ***********************************************************
  logic [1:0] dis_s_q, flt_s_q, los_s_q;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dis_s_q <= 2'h0;
      flt_s_q <= 2'h0;
      los_s_q <= 2'h0;
    end
    else
    begin
      dis_s_q <= {dis_s_q[0], tx_disable};
      flt_s_q <= {flt_s_q[0], laser_fault};
      los_s_q <= {los_s_q[0], rx_power_low};
    end
  end
  wire logic dis = dis_s_q[1];
  wire logic flt = flt_s_q[1];
  wire logic los = los_s_q[1];

  // ***********************************************************
  // transmit state machine
  // ***********************************************************
  tx_ctrl_pkg::tx_state_e st_q, st_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic [CW-1:0] hold_q, hold_d;
  logic fault_q, fault_d;
  logic en_q, en_d;

  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    fault_d = fault_q;
    hold_d = dis ? ((hold_q < CW'(RESET_CYC)) ? hold_q + 1'b1 : hold_q)
                 : '0;
    en_d = 1'b0;
    case (st_q)
      tx_ctrl_pkg::ST_INIT:
      begin
        // laser stays dark while init runs; any fault re-latches
        if (flt)
        begin
          st_d = tx_ctrl_pkg::ST_FAULT;
          fault_d = 1'b1; // [RQ4]
        end
        else if (cnt_q >= CW'(ON_CYCLES - 1))
        begin
          st_d = tx_ctrl_pkg::ST_RUN; // [RQ3]
          fault_d = 1'b0; // [RQ3]
          cnt_d = '0;
        end
        else
          cnt_d = cnt_q + 1'b1;
      end
      tx_ctrl_pkg::ST_RUN:
      begin
        en_d = !dis; // [RQ1] [RQ2]
        if (flt && !dis)
        begin
          st_d = tx_ctrl_pkg::ST_FAULT;
          fault_d = 1'b1; // [RQ4]
        end
      end
      tx_ctrl_pkg::ST_FAULT:
      begin
        fault_d = 1'b1; // [RQ9]
        // only a long enough disable pulse counts as a reset
        if (!dis && hold_q >= CW'(RESET_CYC)) // [RQ5]
        begin
          st_d = tx_ctrl_pkg::ST_INIT;
          cnt_d = '0;
        end
      end
      default:
        st_d = tx_ctrl_pkg::ST_INIT;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= tx_ctrl_pkg::ST_INIT;
      cnt_q <= '0;
      hold_q <= '0;
      fault_q <= 1'b0;
      en_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      hold_q <= hold_d;
      fault_q <= fault_d;
      en_q <= en_d;
    end
  end

  // ***********************************************************
  // signal-lost filter
  // ***********************************************************
  logic [CW-1:0] lcnt_q, lcnt_d;
  logic lost_q, lost_d;
  always_comb
  begin
    lcnt_d = '0;
    lost_d = lost_q;
    if (los)
    begin
      // short dropouts are ignored to honour the minimum delay
      // saturates, so a long outage never wraps and drops the flag
      lcnt_d = (lcnt_q < CW'(LOSS_CYC)) ? lcnt_q + 1'b1 : lcnt_q;
      if (lcnt_q >= CW'(LOSS_CYC - 1))
        lost_d = 1'b1; // [RQ6]
    end
    else
      lost_d = 1'b0; // [RQ7]
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lcnt_q <= '0;
      lost_q <= 1'b0;
    end
    else
    begin
      lcnt_q <= lcnt_d;
      lost_q <= lost_d;
    end
  end

  assign tx_fault = fault_q;
  assign receive_signal_lost = lost_q;
  assign laser_enable = en_q;

  // ***********************************************************
  // checks
  // ***********************************************************
  a_laser_off_fast: assert property (@(posedge clk) // [RQ1]
    disable iff (!rst_n)
    $rose(dis) |-> ##[1:2] !laser_enable)
    else $error("laser not off after disable");
  a_fault_flag_fast: assert property (@(posedge clk) // [RQ4]
    disable iff (!rst_n)
    (flt && !dis && st_q == tx_ctrl_pkg::ST_RUN) |-> ##1 tx_fault)
    else $error("fault flag late");
  a_fault_latched: assert property (@(posedge clk) // [RQ9]
    disable iff (!rst_n)
    (tx_fault && st_q == tx_ctrl_pkg::ST_FAULT && !flt && !dis)
      |-> ##1 tx_fault)
    else $error("fault flag dropped");
  a_short_pulse_kept: assert property (@(posedge clk) // [RQ5]
    disable iff (!rst_n)
    (st_q == tx_ctrl_pkg::ST_FAULT && $fell(dis) && hold_q < CW'(RESET_CYC))
      |-> st_d == tx_ctrl_pkg::ST_FAULT)
    else $error("short pulse cleared fault");
  a_lost_min_delay: assert property (@(posedge clk) // [RQ6]
    disable iff (!rst_n)
    $rose(los) |-> !receive_signal_lost [*2])
    else $error("signal lost too early");
  a_lost_after_count: assert property (@(posedge clk) // [RQ6]
    disable iff (!rst_n)
    receive_signal_lost |-> lcnt_q == CW'(LOSS_CYC))
    else $error("signal lost before full filter count");
  a_lost_clear: assert property (@(posedge clk) // [RQ7]
    disable iff (!rst_n)
    $fell(los) |-> ##[0:1] !receive_signal_lost)
    else $error("signal lost not cleared");
  a_init_clears: assert property (@(posedge clk) // [RQ3]
    disable iff (!rst_n)
    (st_q == tx_ctrl_pkg::ST_INIT && st_d == tx_ctrl_pkg::ST_RUN)
      |-> ##1 !tx_fault)
    else $error("init did not clear fault");
  a_enable_back: assert property (@(posedge clk) // [RQ2]
    disable iff (!rst_n)
    (st_q == tx_ctrl_pkg::ST_RUN && !dis && !flt) |-> ##1 laser_enable)
    else $error("laser not restored");
  a_dark_unless_run: assert property (@(posedge clk) // [RQ9]
    disable iff (!rst_n)
    st_q != tx_ctrl_pkg::ST_RUN |-> ##1 !laser_enable)
    else $error("laser on outside run state");
endmodule
`default_nettype wire

// File: core/tx_ctrl_defines.svh
`ifndef TX_CTRL_DEFINES_SVH
`define TX_CTRL_DEFINES_SVH
// timing limits in ns
`define T_OFF_NS 10000
`define T_ON_NS 1000000
`define T_INIT_NS 300000000
`define T_FAULT_NS 100000
`define T_RESET_NS 10000
`define T_LOSS_MIN_NS 2300
`define T_LOSS_MAX_NS 100000
`define CLK_NS 8
`endif

// File: core/tx_ctrl_pkg.sv
`default_nettype none
package tx_ctrl_pkg;
  typedef enum logic [1:0] {
    ST_INIT = 2'b00,
    ST_RUN = 2'b01,
    ST_FAULT = 2'b11,
    ST_CLEAR = 2'b10
  } tx_state_e;
endpackage
`default_nettype wire

// File: testbench/host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// host controller
// ****************
module host_model #(
  parameter int HOLD = 1250,
  parameter int ID_HALF = 625
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // bench requests and pin
  input wire logic want_off,
  input wire logic short_off,
  output logic tx_disable
);
  logic [11:0] cnt_q;
  logic stretch;
  // id link left idle; a faster half period would break its rate limit
  if (ID_HALF < 625)
  begin : g_id_rate
    $error("id clock half period too short");
  end
  if (HOLD < 1 || HOLD > 4094)
  begin : g_hold_range
    $error("hold does not fit the counter");
  end
  // a request stays high one cycle past the hold, so the pin is high for
  // the full time; short_off bypasses this to try a refused pulse
  assign stretch = cnt_q != 12'h000 && cnt_q <= 12'(HOLD);
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= 12'h000;
    else if (want_off || stretch)
      cnt_q <= (cnt_q <= 12'(HOLD)) ? cnt_q + 12'h001 : cnt_q;
    else
      cnt_q <= 12'h000;
  end
  assign tx_disable = want_off | short_off | stretch;
endmodule
`default_nettype wire

// File: testbench/tb_optical_tx_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) \
  checks_done++; \
  if ((a) !== (e)) \
  begin \
    n_errors++; \
    $display("mismatch %s exp %0h got %0h", n, e, a); \
  end
module tb_optical_tx_ctrl;
  // ****************
  // bench signals
  // ****************
  logic clk = 0, rst_n = 0, want_off = 0, laser_fault = 0;
  logic rx_power_low = 0, short_off = 0;
  logic tx_disable, tx_fault, receive_signal_lost, laser_enable;
  int n_errors = 0, checks_done = 0;
  initial forever #4 clk = ~clk;
  host_model host (.clk(clk), .rst_n(rst_n), .want_off(want_off),
    .short_off(short_off), .tx_disable(tx_disable));
  // short init so the run stays brief
  optical_tx_ctrl #(.INIT_CYCLES(40), .ON_CYCLES(20)) dut (.clk(clk),
    .rst_n(rst_n), .tx_disable(tx_disable), .tx_fault(tx_fault),
    .receive_signal_lost(receive_signal_lost), .laser_fault(laser_fault),
    .rx_power_low(rx_power_low), .laser_enable(laser_enable));
  // ****************
  // scenarios
  // ****************
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic t_init;
    cyc(5);
    `CHK("laser", 1'b0, laser_enable)
    cyc(21);
    `CHK("laser", 1'b1, laser_enable)
    $display("test init done");
  endtask
  task automatic t_disable;
    want_off = 1;
    cyc(1);
    want_off = 0;
    cyc(3);
    `CHK("laser", 1'b0, laser_enable)
    cyc(1280);
    `CHK("laser", 1'b1, laser_enable)
    $display("test disable done");
  endtask
  task automatic t_fault;
    laser_fault = 1;
    cyc(5);
    `CHK("fault", 1'b1, tx_fault)
    `CHK("laser", 1'b0, laser_enable)
    laser_fault = 0;
    cyc(50);
    `CHK("fault", 1'b1, tx_fault)
    short_off = 1;
    cyc(100);
    short_off = 0;
    cyc(10);
    `CHK("fault", 1'b1, tx_fault)
    `CHK("laser", 1'b0, laser_enable)
    want_off = 1;
    cyc(1);
    want_off = 0;
    cyc(1240);
    `CHK("fault", 1'b1, tx_fault)
    cyc(40);
    `CHK("fault", 1'b0, tx_fault)
    `CHK("laser", 1'b1, laser_enable)
    $display("test fault done");
  endtask
  task automatic t_loss;
    rx_power_low = 1;
    cyc(287);
    `CHK("lost", 1'b0, receive_signal_lost)
    cyc(13);
    `CHK("lost", 1'b1, receive_signal_lost)
    rx_power_low = 0;
    cyc(4);
    `CHK("lost", 1'b0, receive_signal_lost)
    $display("test loss done");
  endtask
  task automatic t_reset;
    laser_fault = 1;
    cyc(5);
    `CHK("fault", 1'b1, tx_fault)
    laser_fault = 0;
    rst_n = 0;
    cyc(2);
    `CHK("fault", 1'b0, tx_fault)
    rst_n = 1;
    cyc(5);
    `CHK("laser", 1'b0, laser_enable)
    cyc(21);
    `CHK("fault", 1'b0, tx_fault)
    `CHK("laser", 1'b1, laser_enable)
    $display("test reset done");
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    cyc(6);
    rst_n = 1;
    t_init();
    t_disable();
    t_fault();
    t_loss();
    t_reset();
    print_verdict();
  end
  // run needs about 3100 cycles
  initial
  begin
    #40000;
    n_errors++;
    print_verdict();
  end
endmodule
`default_nettype wire
